// *** hdl/sppa_port.sv ***
// Programmable parallel port with mode 1 strobed input on port A
// Operation
// - Chip select low with both address bits high writes the control register.
// - Bit-set word 01 hex sets port C line 0, other lines kept.
// - Control word 10110000 makes port A mode 1 input, rest outputs except strobe line C4.
// - In mode 1 input the strobe on port C line 4 latches port A.
// - Latching strobed data drives buffer-full on port C line 5 high.
// - Port B takes its own direction independently of port A; it stays in mode 0.
// - Host read of port A drives interrupt request on line 3 low.
//
// The address map and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module sppa_port
  import sppa_pkg::*;
(
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [3:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic wb_ack_out,
  output logic [31:0] wb_dat_out,
  input wire logic cs_n_in,
  input wire logic addr_bit0_in,
  input wire logic addr_bit1_in,
  input wire logic rd_n_in,
  input wire logic wr_n_in,
  input wire logic [7:0] host_data_in,
  output logic [7:0] host_data_out,
  output logic host_data_oe_out,
  input wire logic [7:0] porta_in,
  input wire logic [7:0] portb_in,
  input wire logic [7:0] portc_in,
  output logic [7:0] porta_out,
  output logic [7:0] portb_out,
  output logic [7:0] portc_out,
  output logic [7:0] porta_oe_out,
  output logic [7:0] portb_oe_out,
  output logic [7:0] portc_oe_out,
  output logic irq_out
);
  logic [7:0] ctrl, a_out, b_out, c_out, a_latch, rd_byte;
  logic [7:0] next_ctrl, next_a_out, next_b_out, next_c_out, next_a_latch;
  logic [7:0] next_host_data, next_a_oe, next_b_oe, next_c_oe;
  logic next_host_oe, input_buffer_full_flag, next_ibf, inte, next_inte, port_interrupt_request, next_port_interrupt_request;
  logic rd_n_d, wr_n_d, stb_d, next_irq;
  logic [1:0] status, next_status, mask, next_mask;
  logic [31:0] wb_rd;
  logic wb_req;
  logic wb_take;
  logic [7:0] porta_rd, next_pa, next_pb, next_pc;
  logic [1:0] acc_addr;
  logic host_rd, host_wr, wb_rd_a, rd_a_done, stb_fall, mode1_in;
  logic [7:0] acc_data;
  logic acc_wr;
  sppa_pins_type pins;

  sppa_wb_slave u_wb (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in),
    .wb_we_in(wb_we_in),
    .rd_data_in(wb_rd),
    .wb_ack_out(wb_ack_out),
    .wb_dat_out(wb_dat_out),
    .req_out(wb_req)
  );

  function automatic logic [7:0] dir_mask(input logic is_in);
    dir_mask = is_in ? 8'h00 : 8'hFF;
  endfunction

  function automatic logic is_mode1_in(input logic [7:0] cw);
    is_mode1_in = cw[SPPA_CW_AMODE_LO] & cw[SPPA_CW_AIN];
  endfunction

  assign pins = '{a_in: porta_in, b_in: portb_in, c_in: portc_in};
  assign mode1_in = is_mode1_in(ctrl);
  // Pin strobes act on the edge where rd or wr goes low
  assign host_rd = ~cs_n_in & ~rd_n_in & rd_n_d;
  assign host_wr = ~cs_n_in & ~wr_n_in & wr_n_d;
  assign stb_fall = ~pins.c_in[SPPA_PC_STB] & stb_d;

  // Data register window: byte address 0 carries port select in bits 9:8
  sppa_access_type acc;
  always_comb begin
    acc.addr = {addr_bit1_in, addr_bit0_in};
    acc.we = host_wr;
    acc.data = host_data_in;
    if (wb_req && wb_adr_in == SPPA_REG_DATA) begin
      acc.addr = wb_dat_in[9:8];
      acc.we = wb_we_in & wb_sel_in[0];
      acc.data = wb_dat_in[7:0];
    end
  end
  assign acc_addr = acc.addr;
  assign acc_wr = acc.we & (host_wr | (wb_req & wb_we_in));
  assign acc_data = acc.data;
  // Read side effects fire on the edge that captures the read data, so an
  // event landing between capture and ack is never cleared unseen
  assign wb_take = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  assign wb_rd_a = wb_take & ~wb_we_in & (wb_adr_in == SPPA_REG_DATA);
  assign porta_rd = mode1_in ? a_latch : (ctrl[SPPA_CW_AIN] ? pins.a_in : a_out);

  always_comb begin
    case (acc_addr)
      SPPA_ADDR_PORTA: rd_byte = porta_rd;
      SPPA_ADDR_PORTB: rd_byte = ctrl[SPPA_CW_BIN] ? pins.b_in : b_out;
      SPPA_ADDR_PORTC: rd_byte = mode1_in ? {c_out[7:6], input_buffer_full_flag, pins.c_in[4], port_interrupt_request, c_out[2:0]}
                                          : (pins.c_in & ~portc_oe_out) | (c_out & portc_oe_out);
      default: rd_byte = 8'hFF;
    endcase
  end
  // Wishbone data reads only port A through the window; a read of it counts
  assign rd_a_done = (host_rd & acc_addr == SPPA_ADDR_PORTA) | wb_rd_a;

  always_comb begin
    case (wb_adr_in)
      SPPA_REG_DATA: wb_rd = {24'h000000, porta_rd};
      SPPA_REG_STATUS: wb_rd = {30'h00000000, status};
      SPPA_REG_MASK: wb_rd = {30'h00000000, mask};
      SPPA_REG_STATE: wb_rd = {21'h000000, inte, port_interrupt_request, input_buffer_full_flag, ctrl};
      default: wb_rd = 32'h00000000;
    endcase
  end

  always_comb begin
    next_ctrl = ctrl;
    next_a_out = a_out;
    next_b_out = b_out;
    next_c_out = c_out;
    next_a_latch = a_latch;
    next_ibf = input_buffer_full_flag;
    next_inte = inte;
    next_port_interrupt_request = port_interrupt_request;
    next_status = status;
    next_mask = mask;
    if (acc_wr) begin
      case (acc_addr)
        SPPA_ADDR_PORTA: next_a_out = acc_data;
        SPPA_ADDR_PORTB: next_b_out = acc_data;
        SPPA_ADDR_PORTC: next_c_out = acc_data;
        SPPA_ADDR_CTRL: begin
          if (acc_data[SPPA_CW_MODESET]) begin
            next_ctrl = acc_data;
            next_a_out = SPPA_PORT_RST;
            next_b_out = SPPA_PORT_RST;
            next_c_out = SPPA_PORT_RST;
            next_ibf = 1'b0;
            next_inte = 1'b0;
            next_port_interrupt_request = 1'b0;
          end else begin
            next_c_out[acc_data[3:SPPA_BS_SEL_LO]] = acc_data[SPPA_BS_VAL];
            if (mode1_in && acc_data[3:SPPA_BS_SEL_LO] == 3'(SPPA_PC_STB)) begin
              next_inte = acc_data[SPPA_BS_VAL];
            end
          end
        end
        default: next_c_out = c_out;
      endcase
    end
    if (mode1_in) begin
      if (rd_a_done) begin
        next_port_interrupt_request = 1'b0;
        next_ibf = 1'b0;
      end
      // strobe latch; set wins over a same-cycle read
      if (stb_fall) begin
        next_a_latch = pins.a_in;
        next_ibf = 1'b1;
      end
      // request once strobe is back high
      if (pins.c_in[SPPA_PC_STB] && next_ibf && next_inte) begin
        next_port_interrupt_request = 1'b1;
      end
      if (!next_inte) begin
        next_port_interrupt_request = 1'b0;
      end
    end
    if (wb_req && wb_we_in && wb_adr_in == SPPA_REG_MASK && wb_sel_in[0]) begin
      next_mask = wb_dat_in[1:0];
    end
    // Read clears status; a new event in that cycle survives
    if (wb_take && !wb_we_in && wb_adr_in == SPPA_REG_STATUS) begin
      next_status = 2'h0;
    end
    if (mode1_in && stb_fall) begin
      next_status[SPPA_IRQ_LATCH] = 1'b1;
    end
    if (mode1_in && rd_a_done) begin
      next_status[SPPA_IRQ_READ] = 1'b1;
    end
    next_irq = |(next_status & next_mask);
  end

  always_comb begin
    next_a_oe = dir_mask(next_ctrl[SPPA_CW_AIN]);
    next_b_oe = dir_mask(next_ctrl[SPPA_CW_BIN]);
    next_c_oe = {{4{~next_ctrl[SPPA_CW_CHI_IN]}}, {4{~next_ctrl[SPPA_CW_CLO_IN]}}};
    if (is_mode1_in(next_ctrl)) begin
      // Handshake lines: strobe in, buffer-full and request out
      next_c_oe[SPPA_PC_STB] = 1'b0;
      next_c_oe[SPPA_PC_IBF] = 1'b1;
      next_c_oe[SPPA_PC_PORT_INTERRUPT_REQUEST] = 1'b1;
    end
    next_host_oe = ~cs_n_in & ~rd_n_in;
    next_host_data = rd_byte;
  end

  // Port and handshake state
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctrl <= SPPA_CTRL_RST;
      a_out <= SPPA_PORT_RST;
      b_out <= SPPA_PORT_RST;
      c_out <= SPPA_PORT_RST;
      a_latch <= SPPA_PORT_RST;
      input_buffer_full_flag <= 1'b0;
      inte <= 1'b0;
      port_interrupt_request <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      a_out <= next_a_out;
      b_out <= next_b_out;
      c_out <= next_c_out;
      a_latch <= next_a_latch;
      input_buffer_full_flag <= next_ibf;
      inte <= next_inte;
      port_interrupt_request <= next_port_interrupt_request;
    end
  end

  // Interrupt status, mask and request
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      status <= SPPA_IRQ_RST;
      mask <= SPPA_IRQ_RST;
      irq_out <= 1'b0;
    end else begin
      status <= next_status;
      mask <= next_mask;
      irq_out <= next_irq;
    end
  end

  // Edge samplers reset to the idle high level, so no false edge follows reset
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rd_n_d <= 1'b1;
      wr_n_d <= 1'b1;
      stb_d <= 1'b1;
    end else begin
      rd_n_d <= rd_n_in;
      wr_n_d <= wr_n_in;
      stb_d <= pins.c_in[SPPA_PC_STB];
    end
  end

  // Handshake lines overlay port C only while port A is a mode 1 input
  always_comb begin
    next_pa = next_a_out;
    next_pb = next_b_out;
    next_pc = next_c_out;
    if (is_mode1_in(next_ctrl)) begin
      next_pc = {next_c_out[7:6], next_ibf, 1'b0, next_port_interrupt_request, next_c_out[2:0]};
    end
  end

  // Pin-side outputs
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      host_data_out <= SPPA_PORT_RST;
      host_data_oe_out <= 1'b0;
      porta_oe_out <= 8'h00;
      portb_oe_out <= 8'h00;
      portc_oe_out <= 8'h00;
      porta_out <= SPPA_PORT_RST;
      portb_out <= SPPA_PORT_RST;
      portc_out <= SPPA_PORT_RST;
    end else begin
      host_data_out <= next_host_data;
      host_data_oe_out <= next_host_oe;
      porta_oe_out <= next_a_oe;
      portb_oe_out <= next_b_oe;
      portc_oe_out <= next_c_oe;
      porta_out <= next_pa;
      portb_out <= next_pb;
      portc_out <= next_pc;
    end
  end
endmodule

// *** hdl/sppa_pkg.sv ***
// Package: constants and carriers for the strobed parallel port A block
package sppa_pkg;
  // Port addresses selected by addr_bit1:addr_bit0
  localparam logic [1:0] SPPA_ADDR_PORTA = 2'h0;
  localparam logic [1:0] SPPA_ADDR_PORTB = 2'h1;
  localparam logic [1:0] SPPA_ADDR_PORTC = 2'h2;
  localparam logic [1:0] SPPA_ADDR_CTRL = 2'h3;
  // Wishbone register offsets (byte addresses)
  localparam logic [3:0] SPPA_REG_DATA = 4'h0;
  localparam logic [3:0] SPPA_REG_STATUS = 4'h4;
  localparam logic [3:0] SPPA_REG_MASK = 4'h8;
  localparam logic [3:0] SPPA_REG_STATE = 4'hC;
  // Control word fields
  localparam int SPPA_CW_MODESET = 7;
  localparam int SPPA_CW_AMODE_LO = 5;
  localparam int SPPA_CW_AIN = 4;
  localparam int SPPA_CW_CHI_IN = 3;
  localparam int SPPA_CW_BMODE = 2;
  localparam int SPPA_CW_BIN = 1;
  localparam int SPPA_CW_CLO_IN = 0;
  localparam int SPPA_BS_VAL = 0;
  localparam int SPPA_BS_SEL_LO = 1;
  // Port C line positions in mode 1 input
  localparam int SPPA_PC_PORT_INTERRUPT_REQUEST = 3;
  localparam int SPPA_PC_STB = 4;
  localparam int SPPA_PC_IBF = 5;
  // Reset values: all ports inputs, mode 0
  localparam logic [7:0] SPPA_CTRL_RST = 8'h9B;
  localparam logic [7:0] SPPA_PORT_RST = 8'h00;
  localparam logic [1:0] SPPA_IRQ_RST = 2'h0;
  // Interrupt status bits
  localparam int SPPA_IRQ_LATCH = 0;
  localparam int SPPA_IRQ_READ = 1;

  typedef struct packed {
    logic [1:0] addr;
    logic we;
    logic [7:0] data;
  } sppa_access_type;

  typedef struct packed {
    logic [7:0] a_in;
    logic [7:0] b_in;
    logic [7:0] c_in;
  } sppa_pins_type;
endpackage

// *** hdl/sppa_wb_slave.sv ***
// Classic Wishbone slave front end producing one access pulse per cycle
`timescale 1ns/1ps
module sppa_wb_slave
  import sppa_pkg::*;
(
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [31:0] rd_data_in,
  output logic wb_ack_out,
  output logic [31:0] wb_dat_out,
  output logic req_out
);
  logic next_ack;
  logic [31:0] next_dat;

  // Answer one cycle after the request; ack drops the cycle after
  always_comb begin
    next_ack = wb_cyc_in & wb_stb_in & ~wb_ack_out;
    // Write answers carry zero data
    next_dat = (next_ack && !wb_we_in) ? rd_data_in : 32'h00000000;
  end

  // Access takes effect on the edge that samples ack
  assign req_out = wb_ack_out & wb_cyc_in & wb_stb_in;

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h00000000;
    end else begin
      wb_ack_out <= next_ack;
      wb_dat_out <= next_dat;
    end
  end
endmodule

// *** test/sppa_port_asserts.sv ***
// Concurrent checks on the port block pins
`timescale 1ns/1ps
module sppa_port_asserts
  import sppa_pkg::*;
(
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic wb_ack_out,
  input wire logic wb_we_in,
  input wire logic [3:0] wb_adr_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic cs_n_in,
  input wire logic addr_bit0_in,
  input wire logic addr_bit1_in,
  input wire logic wr_n_in,
  input wire logic [7:0] host_data_in,
  input wire logic [7:0] portc_in,
  input wire logic [7:0] portb_out,
  input wire logic [7:0] portc_out,
  input wire logic [7:0] porta_oe_out,
  input wire logic [7:0] portb_oe_out,
  input wire logic [7:0] portc_oe_out
);
  logic m1;
  logic sel3;
  logic sel1;
  logic rd_a;
  // Mode 1 input is only visible through the enables
  assign m1 = porta_oe_out == 8'h00 && portc_oe_out[5] && !portc_oe_out[4];
  assign sel3 = !cs_n_in && addr_bit1_in && addr_bit0_in;
  assign sel1 = !cs_n_in && !addr_bit1_in && addr_bit0_in;
  assign rd_a = wb_ack_out && !wb_we_in && wb_adr_in == SPPA_REG_DATA && m1;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  property p_ctrl;
    sel3 && $fell(wr_n_in) && host_data_in == 8'h80 |-> ##[1:4] porta_oe_out == 8'hFF;
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("control write ignored");
  property p_bitset;
    sel3 && $fell(wr_n_in) && host_data_in == 8'h01 && portc_oe_out[0]
      |-> ##[1:4] portc_out[0];
  endproperty
  a_bitset: assert property (p_bitset) else $error("bit set lost");
  property p_mode;
    wb_ack_out && wb_we_in && wb_adr_in == SPPA_REG_DATA && wb_dat_in[9:0] == 10'h3B0
      |-> ##[0:3] (m1 && portb_oe_out == 8'hFF && !portc_oe_out[4]);
  endproperty
  a_mode: assert property (p_mode) else $error("mode word not applied");
  property p_latch;
    m1 && $fell(portc_in[4]) |-> ##[1:3] portc_out[5];
  endproperty
  a_latch: assert property (p_latch) else $error("buffer full not set");
  property p_port_interrupt_request;
    m1 && portc_out[3] |-> portc_out[5];
  endproperty
  a_port_interrupt_request: assert property (p_port_interrupt_request) else $error("request without data");
  property p_portb;
    sel1 && $fell(wr_n_in) && portb_oe_out == 8'hFF |-> ##[1:4] portb_out == host_data_in;
  endproperty
  a_portb: assert property (p_portb) else $error("port b write lost");
  property p_rd_port_interrupt_request;
    rd_a |-> ##[0:2] !portc_out[3];
  endproperty
  a_rd_port_interrupt_request: assert property (p_rd_port_interrupt_request) else $error("request kept after read");
  property p_rd_ibf;
    rd_a |-> ##[0:2] !portc_out[5];
  endproperty
  a_rd_ibf: assert property (p_rd_ibf) else $error("buffer full kept");
endmodule

bind sppa_port sppa_port_asserts i_chk (.mclk_in(mclk_in), .nrst_in(nrst_in),
  .wb_ack_out(wb_ack_out), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
  .wb_dat_in(wb_dat_in), .cs_n_in(cs_n_in), .addr_bit0_in(addr_bit0_in),
  .addr_bit1_in(addr_bit1_in), .wr_n_in(wr_n_in), .host_data_in(host_data_in),
  .portc_in(portc_in), .portb_out(portb_out), .portc_out(portc_out),
  .porta_oe_out(porta_oe_out), .portb_oe_out(portb_oe_out), .portc_oe_out(portc_oe_out));

// *** test/sppa_term.sv ***
// Terminal model: presents data and pulses the strobe low
`timescale 1ns/1ps
module sppa_term (
  input wire logic mclk_in,
  input wire logic go_in,
  input wire logic [7:0] data_in,
  input wire logic [3:0] width_in,
  output logic [7:0] porta_out,
  output logic stb_n_out
);
  int n;
  initial begin
    porta_out = 8'hFF;
    stb_n_out = 1'b1;
    forever begin
      @(posedge mclk_in);
      if (go_in) begin
        porta_out <= data_in;
        @(posedge mclk_in);
        stb_n_out <= 1'b0;
        // Width of at least one cycle keeps the strobe edges apart
        for (n = 0; n < width_in; n++) @(posedge mclk_in);
        stb_n_out <= 1'b1;
        @(posedge mclk_in);
        // Released bus shows the inverse, not the old data
        porta_out <= ~data_in;
      end
    end
  end
endmodule

// *** test/test_strobed_parallel_port_a.sv ***
// Bench for the strobed parallel port block
`timescale 1ns/1ps
module test_strobed_parallel_port_a;
  import sppa_pkg::*;
  logic mclk_in, nrst_in, cyc, we, ack, cs_n, a0, a1, rd_n, wr_n, irq, stb_n, go;
  logic hoe, hso;
  logic [3:0] adr, wid;
  logic [31:0] wdat, wbq, rdat;
  logic [7:0] hd, hq, hs, pd, tdat, pa, pb, pc, aoe, boe, coe;
  logic [17:0] rows [4] = '{{2'h0, 8'h5A, 8'h5A}, {2'h1, 8'hC3, 8'hC3},
    {2'h2, 8'h3C, 8'h3C}, {2'h3, 8'h01, 8'h3D}};
  int miscompares, compares, i;
  sppa_port i_dut (.mclk_in(mclk_in), .nrst_in(nrst_in), .wb_cyc_in(cyc), .wb_stb_in(cyc),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'h1), .wb_dat_in(wdat), .wb_ack_out(ack),
    .wb_dat_out(wbq), .cs_n_in(cs_n), .addr_bit0_in(a0), .addr_bit1_in(a1), .rd_n_in(rd_n),
    .wr_n_in(wr_n), .host_data_in(hd), .host_data_out(hq), .host_data_oe_out(hoe),
    .porta_in(pd), .portb_in(8'h00), .portc_in({3'h0, stb_n, 4'h0}), .porta_out(pa),
    .portb_out(pb), .portc_out(pc), .porta_oe_out(aoe), .portb_oe_out(boe),
    .portc_oe_out(coe), .irq_out(irq));
  sppa_term i_term (.mclk_in(mclk_in), .go_in(go), .data_in(tdat), .width_in(wid),
    .porta_out(pd), .stb_n_out(stb_n));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    for (k = 0; k < 20 && ack !== 1'b1; k++) @(posedge mclk_in);
    if (k >= 20) begin
      miscompares++;
      end_sim;
    end
    rdat = wbq;
    cyc <= 1'b0;
    @(posedge mclk_in);
  endtask
  task automatic pin(input logic r, input logic [1:0] a, input logic [7:0] d);
    cs_n <= 1'b0;
    {a1, a0} <= a;
    hd <= d;
    @(posedge mclk_in);
    if (r) rd_n <= 1'b0;
    else wr_n <= 1'b0;
    repeat (3) @(posedge mclk_in);
    hs = hq;
    hso = hoe;
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    @(posedge mclk_in);
    cs_n <= 1'b1;
    repeat (4) @(posedge mclk_in);
  endtask
  task automatic strobe(input logic [7:0] d, input logic [3:0] w);
    int k;
    tdat <= d;
    wid <= w;
    go <= 1'b1;
    @(posedge mclk_in);
    go <= 1'b0;
    for (k = 0; k < 40 && pc[3] !== 1'b1; k++) @(posedge mclk_in);
    if (k >= 40) begin
      miscompares++;
      end_sim;
    end
  endtask
  initial begin
    mclk_in = 1'b0;
    forever #50 mclk_in = ~mclk_in;
  end
  initial begin
    {nrst_in, cyc, we, go, adr, wdat, hd, tdat, wid} <= '0;
    {cs_n, rd_n, wr_n, a0, a1} <= 5'h1C;
    repeat (8) @(posedge mclk_in);
    chk({aoe, coe, pc, ack}, 25'h0);
    nrst_in <= 1'b1;
    @(posedge mclk_in);
    wb(1'b0, SPPA_REG_STATE, 32'h0);
    chk(rdat[10:0], 11'h09B);
    wb(1'b0, 4'h2, 32'h0);
    chk(rdat, 32'h0);
    pin(1'b0, 2'h3, 8'h80);
    for (i = 0; i < 4; i++) begin
      pin(1'b0, rows[i][17:16], rows[i][15:8]);
      chk(rows[i][17:16] == 0 ? pa : rows[i][17:16] == 1 ? pb : pc, rows[i][7:0]);
    end
    wb(1'b1, SPPA_REG_DATA, 32'h3B0);
    chk({aoe, boe}, 16'h00FF);
    pin(1'b0, 2'h1, 8'hA5);
    chk(pb, 8'hA5);
    wb(1'b1, SPPA_REG_MASK, 32'h3);
    pin(1'b0, 2'h3, 8'h09);
    strobe(8'h96, 4'h2);
    chk({pc[5], pc[3], irq}, 3'h7);
    wb(1'b0, SPPA_REG_STATUS, 32'h0);
    chk({rdat[1:0], irq}, 3'h2);
    wb(1'b0, SPPA_REG_DATA, 32'h0);
    chk({rdat[7:0], pc[5], pc[3], irq}, 11'h4B1);
    wb(1'b1, SPPA_REG_MASK, 32'h0);
    strobe(8'h69, 4'h6);
    chk({pc[5], pc[3], irq}, 3'h6);
    pin(1'b1, 2'h0, 8'h00);
    chk({hso, hs, pc[5], pc[3]}, 11'h5A4);
    // Reset in mid-run returns the power-up state
    nrst_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    chk({aoe, coe, pc, ack, irq}, 26'h0);
    nrst_in <= 1'b1;
    @(posedge mclk_in);
    wb(1'b0, SPPA_REG_STATE, 32'h0);
    chk(rdat[10:0], 11'h09B);
    end_sim;
  end
endmodule
